// File: pkg/rdbl_defs.svh
/*
 Constants of the resource data boot loader: validation pattern, image layout,
 RAM capacity and read limits. Assumes byte addressing of the serial memory.
*/
`ifndef RDBL_DEFS_SVH
`define RDBL_DEFS_SVH
`define RDBL_SIG0 8'h55
`define RDBL_SIG1 8'hAA
`define RDBL_A_SIG0 9'h000
`define RDBL_A_SIG1 9'h001
`define RDBL_A_LENH 9'h002
`define RDBL_A_LENL 9'h003
`define RDBL_A_BODY 9'h004
`define RDBL_RAM_BYTES 9'h100
`define RDBL_MAX_READS 9'h104
`define RDBL_ID_OFS 8'h07
`define RDBL_ID_LAST 7'h47
`endif

// File: pkg/rdbl_pkg.sv
/*
 Types of the resource data boot loader: loader states and the memory read
 request carrier. Assumes rdbl_defs.svh supplies the numeric constants.
*/
package rdbl_pkg;
   typedef enum logic [2:0] {
      RDBL_PROBE0 = 3'b000,
      RDBL_PROBE1 = 3'b001,
      RDBL_LEN0 = 3'b010,
      RDBL_LEN1 = 3'b011,
      RDBL_COPY = 3'b100,
      RDBL_DONE = 3'b101,
      RDBL_HOST = 3'b110
   } rdbl_state_t;

   typedef struct packed {
      logic req;
      logic [8:0] addr;
   } rdbl_mem_req_t;
endpackage

// File: rtl/rdbl_loader.sv
/*
 Resource data boot loader: probes the serial memory, copies a valid image
 into the resource RAM, otherwise accepts a host download, then serves
 resource reads and the serial identifier for isolation.
 Assumes a byte read port to the serial memory on sys_clk: request held until
 a one-cycle rd_valid returns the byte. Host and isolation strobes are on sys_clk.
*/
`timescale 1ns/1ps
`include "rdbl_defs.svh"

module rdbl_loader (
   input wire logic sys_clk, // 100 MHz clock
   input wire logic rst, // Async reset, active high
   output rdbl_pkg::rdbl_mem_req_t mem_rq, // Memory read request and byte address
   input wire logic rd_valid, // Memory byte returned, one cycle
   input wire logic [7:0] rd_data, // Memory byte
   input wire logic hl_we, // Host download byte strobe
   input wire logic [7:0] hl_data, // Host download byte
   input wire logic hl_done, // Host download finished, pulse
   input wire logic [7:0] rr_addr, // Resource read address
   output logic [7:0] rr_data, // Resource read data, one cycle later
   input wire logic iso_load, // Restart identifier serialisation
   input wire logic iso_shift, // Advance to next identifier bit
   output logic iso_bit, // Current identifier bit
   output logic ram_valid, // RAM content valid
   output logic host_needed // No valid memory image, awaiting download
);
   rdbl_pkg::rdbl_state_t st_ff;
   rdbl_pkg::rdbl_state_t nxt_st;
   logic [7:0] ram_ff [0:255];
   logic [7:0] b0_ff; // First probe byte
   logic [15:0] len_ff; // Length field
   logic [8:0] lim_ff; // Bytes to copy
   logic [8:0] cnt_ff; // Bytes copied so far
   logic [8:0] addr_ff; // Memory byte address
   logic [8:0] hl_ptr_ff; // Host download pointer
   logic [8:0] rd_cnt_ff; // Memory bytes taken
   logic [6:0] bit_idx_ff; // Identifier bit index
   logic valid_ff;
   logic copy_last;
   logic sig_ok;
   logic ee_we;
   logic hl_wr;
   logic [7:0] id_byte;

   assign sig_ok = (b0_ff == `RDBL_SIG0) && (rd_data == `RDBL_SIG1);
   assign copy_last = (cnt_ff + 9'h001) == lim_ff;
   assign ee_we = (st_ff == rdbl_pkg::RDBL_COPY) && rd_valid;
   // host bytes go from RAM byte 0 on, header absent
   assign hl_wr = (st_ff == rdbl_pkg::RDBL_HOST) && hl_we && !hl_ptr_ff[8] && !valid_ff;
   assign ram_valid = valid_ff;
   assign host_needed = (st_ff == rdbl_pkg::RDBL_HOST) && !valid_ff;

   // Request is a level held while waiting for each byte
   always_comb begin
      mem_rq.addr = addr_ff;
      case (st_ff)
         rdbl_pkg::RDBL_PROBE0, rdbl_pkg::RDBL_PROBE1,
         rdbl_pkg::RDBL_LEN0, rdbl_pkg::RDBL_LEN1,
         rdbl_pkg::RDBL_COPY: mem_rq.req = 1'b1;
         default: mem_rq.req = 1'b0;
      endcase
   end

   // Sequencer: probe, length, copy or fall back to host download
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         rdbl_pkg::RDBL_PROBE0: begin
            if (rd_valid) begin
               nxt_st = rdbl_pkg::RDBL_PROBE1;
            end
         end
         rdbl_pkg::RDBL_PROBE1: begin
            if (rd_valid) begin
               // copy only behind the matching pattern
               // a mismatch leaves the RAM to the host
               nxt_st = sig_ok ? rdbl_pkg::RDBL_LEN0 : rdbl_pkg::RDBL_HOST;
            end
         end
         rdbl_pkg::RDBL_LEN0: begin
            if (rd_valid) begin
               nxt_st = rdbl_pkg::RDBL_LEN1;
            end
         end
         rdbl_pkg::RDBL_LEN1: begin
            if (rd_valid) begin
               nxt_st = ({len_ff[15:8], rd_data} == 16'h0000) ? rdbl_pkg::RDBL_DONE
                                                                : rdbl_pkg::RDBL_COPY;
            end
         end
         rdbl_pkg::RDBL_COPY: begin
            // stop at the length count or RAM capacity
            if (rd_valid && copy_last) begin
               nxt_st = rdbl_pkg::RDBL_DONE;
            end
         end
         rdbl_pkg::RDBL_DONE: nxt_st = rdbl_pkg::RDBL_DONE;
         rdbl_pkg::RDBL_HOST: nxt_st = rdbl_pkg::RDBL_HOST;
         default: nxt_st = rdbl_pkg::RDBL_PROBE0;
      endcase
   end

   // State register; reset always restarts with the probe
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_ff <= rdbl_pkg::RDBL_PROBE0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // address starts at the first probe byte and steps per byte, holding at the last copied byte
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         addr_ff <= `RDBL_A_SIG0;
      end else if (rd_valid && mem_rq.req && !(st_ff == rdbl_pkg::RDBL_COPY && copy_last)) begin
         addr_ff <= addr_ff + 9'h001;
      end
   end

   // Probe and length bytes; length is high byte first
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         b0_ff <= 8'h00;
         len_ff <= 16'h0000;
         lim_ff <= 9'h000;
      end else if (rd_valid) begin
         if (st_ff == rdbl_pkg::RDBL_PROBE0) begin
            b0_ff <= rd_data;
         end
         if (st_ff == rdbl_pkg::RDBL_LEN0) begin
            len_ff[15:8] <= rd_data;
         end
         if (st_ff == rdbl_pkg::RDBL_LEN1) begin
            len_ff[7:0] <= rd_data;
            // never more than the RAM holds, so at most 260 reads with the header
            lim_ff <= ({len_ff[15:8], rd_data} > {7'h00, `RDBL_RAM_BYTES}) ? `RDBL_RAM_BYTES
                                                                            : {len_ff[8], rd_data};
         end
      end
   end

   // Copy counter, also the RAM write index
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= 9'h000;
      end else if (ee_we) begin
         cnt_ff <= cnt_ff + 9'h001;
      end
   end

   // Host download pointer saturates at capacity; extra bytes are dropped
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hl_ptr_ff <= 9'h000;
      end else if (hl_wr) begin
         hl_ptr_ff <= hl_ptr_ff + 9'h001;
      end
   end

   // Resource RAM, written by at most one of the two load paths
   always_ff @(posedge sys_clk) begin
      if (ee_we) begin
         ram_ff[cnt_ff[7:0]] <= rd_data;
      end else if (hl_wr) begin
         ram_ff[hl_ptr_ff[7:0]] <= hl_data;
      end
   end

   // valid after the copy, or after the host says it is done
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         valid_ff <= 1'b0;
      end else if (nxt_st == rdbl_pkg::RDBL_DONE ||
                   (st_ff == rdbl_pkg::RDBL_HOST && hl_done)) begin
         valid_ff <= 1'b1;
      end
   end

   // reads return zero until the content is valid
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rr_data <= 8'h00;
      end else begin
         rr_data <= valid_ff ? ram_ff[rr_addr] : 8'h00;
      end
   end

   // bit index over the 72 identifier bits, wraps after the last
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bit_idx_ff <= 7'h00;
      end else if (iso_load) begin
         bit_idx_ff <= 7'h00;
      end else if (iso_shift) begin
         bit_idx_ff <= (bit_idx_ff == `RDBL_ID_LAST) ? 7'h00 : bit_idx_ff + 7'h01;
      end
   end

   // identifier sits right after the seven config bytes, LSB first
   assign id_byte = ram_ff[`RDBL_ID_OFS + {4'h0, bit_idx_ff[6:3]}];

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         iso_bit <= 1'b0;
      end else begin
         iso_bit <= valid_ff & id_byte[bit_idx_ff[2:0]];
      end
   end

   // Count of bytes taken from memory, only checked below
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rd_cnt_ff <= 9'h000;
      end else if (rd_valid && mem_rq.req) begin
         rd_cnt_ff <= rd_cnt_ff + 9'h001;
      end
   end

   // Checks on the load sequence
   a_probe_addr_zero: assert property (@(posedge sys_clk) disable iff (rst)
      (st_ff == rdbl_pkg::RDBL_PROBE0) |-> (mem_rq.req && mem_rq.addr == `RDBL_A_SIG0))
      else $error("probe did not read byte 0");
   a_copy_after_sig: assert property (@(posedge sys_clk) disable iff (rst)
      (st_ff == rdbl_pkg::RDBL_PROBE1 && rd_valid && sig_ok)
      |=> (st_ff == rdbl_pkg::RDBL_LEN0 && mem_rq.addr == `RDBL_A_LENH))
      else $error("valid pattern did not start length read");
   a_mismatch_host: assert property (@(posedge sys_clk) disable iff (rst)
      (st_ff == rdbl_pkg::RDBL_PROBE1 && rd_valid && !sig_ok)
      |=> (host_needed && !mem_rq.req) [*3])
      else $error("bad pattern did not hand over to host");
   a_ram_index_bound: assert property (@(posedge sys_clk) disable iff (rst)
      ee_we |-> (cnt_ff < `RDBL_RAM_BYTES))
      else $error("copy beyond RAM capacity");
   a_read_count_limit: assert property (@(posedge sys_clk) disable iff (rst)
      rd_cnt_ff <= `RDBL_MAX_READS)
      else $error("more than 260 memory bytes read");
   a_copy_len_stop: assert property (@(posedge sys_clk) disable iff (rst)
      (ee_we && copy_last) |=> (!mem_rq.req && valid_ff && cnt_ff == lim_ff))
      else $error("copy did not stop at limit");
   a_len_cap_lim: assert property (@(posedge sys_clk) disable iff (rst)
      (st_ff == rdbl_pkg::RDBL_COPY) |->
      (lim_ff != 9'h000 && {7'h00, lim_ff} <= len_ff && lim_ff <= `RDBL_RAM_BYTES))
      else $error("copy limit is not the capped length");
   a_read_gate_valid: assert property (@(posedge sys_clk) disable iff (rst)
      !valid_ff |=> (rr_data == 8'h00 && !iso_bit))
      else $error("data served before RAM valid");
   a_id_index_wrap: assert property (@(posedge sys_clk) disable iff (rst)
      (iso_shift && !iso_load && bit_idx_ff == `RDBL_ID_LAST) |=> bit_idx_ff == 7'h00)
      else $error("identifier index did not wrap after 72 bits");
   a_host_ptr_step: assert property (@(posedge sys_clk) disable iff (rst)
      hl_wr |=> (hl_ptr_ff == $past(hl_ptr_ff) + 9'h001))
      else $error("host pointer did not advance");

   c_ee_load: cover property (@(posedge sys_clk) disable iff (rst)
      (st_ff == rdbl_pkg::RDBL_COPY) ##[1:300] valid_ff);
   c_host_load: cover property (@(posedge sys_clk) disable iff (rst)
      hl_wr ##[1:300] (hl_done && host_needed));
   c_len_capped: cover property (@(posedge sys_clk) disable iff (rst)
      ee_we && copy_last && lim_ff == `RDBL_RAM_BYTES);
   c_id_wrap: cover property (@(posedge sys_clk) disable iff (rst)
      valid_ff && iso_shift && bit_idx_ff == `RDBL_ID_LAST);
endmodule // rdbl_loader

// File: test/rdbl_mem_model.sv
/*
 Behavioural serial memory that answers byte reads of the loader.
 Assumes the loader's request/valid handshake on sys_clk; the bench fills img.
*/
`timescale 1ns/1ps
module rdbl_mem_model (
   input wire logic sys_clk, // Clock
   input wire logic rst, // Async reset, active high
   input wire rdbl_pkg::rdbl_mem_req_t mem_rq, // Read request
   input wire logic [3:0] lat, // Answer delay in cycles
   output logic rd_valid, // Byte valid pulse
   output logic [7:0] rd_data, // Byte, toggling when not valid
   output logic [9:0] n_reads // Bytes handed out
);
   // image layout laid down by the bench
   logic [7:0] img [0:511];
   logic [3:0] wait_ff;
   // Answer after a delay; the byte line toggles between answers so nothing stale passes
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rd_valid <= 1'b0;
         rd_data <= 8'h00;
         wait_ff <= 4'h0;
         n_reads <= 10'h000;
      end else if (mem_rq.req && !rd_valid && wait_ff >= lat) begin
         rd_valid <= 1'b1;
         rd_data <= img[mem_rq.addr];
         wait_ff <= 4'h0;
         n_reads <= n_reads + 10'h001;
      end else begin
         rd_valid <= 1'b0;
         rd_data <= ~rd_data;
         wait_ff <= mem_rq.req ? wait_ff + 4'h1 : 4'h0;
      end
   end
endmodule // rdbl_mem_model

// File: test/rdbl_loader_tb.sv
/*
 Self-checking bench of the boot loader: memory images, bad probes, host loads.
 Assumes rdbl_mem_model on the memory port and a 100 MHz clock.
*/
`timescale 1ns/1ps
module rdbl_loader_tb;
   logic sys_clk, rst, rd_valid, hl_we, hl_done, iso_load, iso_shift, iso_bit;
   logic ram_valid, host_needed;
   logic [7:0] rd_data, hl_data, rr_addr, rr_data;
   logic [3:0] lat;
   logic [9:0] n_reads;
   logic [15:0] lens [0:4];
   logic [7:0] exp_ram [0:255];
   rdbl_pkg::rdbl_mem_req_t mem_rq;
   int err_total, n_tests, cyc, k, n;
   // Vendor and product codes of the image; the value is arbitrary
   localparam logic [31:0] ID_CODES = 32'h5A3C1E2D;
   rdbl_loader rdbl_loader_inst (.sys_clk(sys_clk), .rst(rst), .mem_rq(mem_rq),
      .rd_valid(rd_valid), .rd_data(rd_data), .hl_we(hl_we), .hl_data(hl_data),
      .hl_done(hl_done), .rr_addr(rr_addr), .rr_data(rr_data), .iso_load(iso_load),
      .iso_shift(iso_shift), .iso_bit(iso_bit), .ram_valid(ram_valid),
      .host_needed(host_needed));
   rdbl_mem_model rdbl_mem_model_inst (.sys_clk(sys_clk), .rst(rst), .mem_rq(mem_rq),
      .lat(lat), .rd_valid(rd_valid), .rd_data(rd_data), .n_reads(n_reads));
   // Bytes copied: the length field, capped at RAM capacity
   function automatic int copy_cnt(logic [15:0] len);
      return (len > 16'h0100) ? 256 : int'(len);
   endfunction
   task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
      n_tests++;
      if (exp !== got) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish;
      $display("mismatches %0d comparisons %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Fill the image, reset for 12 cycles, wait until the loader settles
   task automatic boot(logic [7:0] s0, logic [7:0] s1, logic [15:0] len);
      int i;
      logic [7:0] sum;
      // check bytes, then the length high byte first
      rdbl_mem_model_inst.img[0] = s0;
      rdbl_mem_model_inst.img[1] = s1;
      rdbl_mem_model_inst.img[2] = len[15:8];
      rdbl_mem_model_inst.img[3] = len[7:0];
      for (i = 4; i < 512; i++) rdbl_mem_model_inst.img[i] = 8'($urandom);
      // vendor and product codes sit right after the seven config bytes
      for (i = 0; i < 4; i++) rdbl_mem_model_inst.img[11 + i] = ID_CODES[31 - 8 * i -: 8];
      // stand-in check byte over the code and serial bytes; the loader serialises it as the last identifier byte
      sum = 8'h00;
      for (i = 11; i < 19; i++) sum = sum ^ rdbl_mem_model_inst.img[i];
      rdbl_mem_model_inst.img[19] = sum;
      // version 1.0 pattern; string and device data stay random bytes
      rdbl_mem_model_inst.img[20] = 8'h0A;
      rdbl_mem_model_inst.img[21] = 8'h10;
      rdbl_mem_model_inst.img[22] = 8'h00;
      for (i = 0; i < 256; i++) exp_ram[i] = rdbl_mem_model_inst.img[i + 4];
      rst <= 1'b1;
      lat <= 4'($urandom_range(0, 3));
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      for (i = 0; i < 4000 && ram_valid !== 1'b1 && host_needed !== 1'b1; i++)
         @(posedge sys_clk);
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic rd_cmp(int cnt);
      int a;
      for (a = 0; a < cnt; a++) begin
         @(posedge sys_clk) rr_addr <= 8'(a);
         @(posedge sys_clk) #1;
         chk("rr_data", {2'h0, exp_ram[a]}, {2'h0, rr_data});
      end
   endtask
   // Load, then one shift per bit; the bit shows two edges after its strobe
   task automatic iso_cmp;
      int i;
      @(posedge sys_clk) iso_load <= 1'b1;
      for (i = 0; i < 72; i++) begin
         @(posedge sys_clk) iso_load <= 1'b0;
         iso_shift <= 1'b0;
         @(posedge sys_clk) #1;
         chk("iso_bit", {9'h000, exp_ram[7 + i / 8][i % 8]}, {9'h000, iso_bit});
         @(posedge sys_clk) iso_shift <= 1'b1;
      end
      @(posedge sys_clk) iso_shift <= 1'b0;
   endtask
   // Host bytes go to RAM from address 0; with keep set they must be dropped
   task automatic host_load(int cnt, bit keep);
      int i;
      for (i = 0; i < cnt; i++) begin
         if (!keep) exp_ram[i] = 8'($urandom);
         @(posedge sys_clk) hl_we <= 1'b1;
         hl_data <= keep ? ~exp_ram[i] : exp_ram[i];
      end
      @(posedge sys_clk) hl_we <= 1'b0;
      hl_done <= 1'b1;
      @(posedge sys_clk) hl_done <= 1'b0;
      @(posedge sys_clk) #1;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Hang guard, well beyond the longest expected run
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 80000) begin
         err_total++;
         tally_and_finish();
      end
   end
   initial begin
      rst = 1'b1;
      hl_we = 1'b0;
      hl_data = 8'h00;
      hl_done = 1'b0;
      rr_addr = 8'h00;
      iso_load = 1'b0;
      iso_shift = 1'b0;
      lat = 4'h0;
      void'($urandom(32'h8CE50366));
      lens = '{16'h0000, 16'h0001, 16'($urandom_range(16, 255)), 16'h0100, 16'hFFFF};
      // Valid images: empty, one byte, random, full and over capacity
      for (k = 0; k < 5; k++) begin
         boot(8'h55, 8'hAA, lens[k]);
         n = copy_cnt(lens[k]);
         chk("ram_valid", 10'h001, {9'h000, ram_valid});
         chk("host_needed", 10'h000, {9'h000, host_needed});
         chk("n_reads", 10'(4 + n), n_reads);
         rd_cmp(n);
         if (n >= 16) iso_cmp();
         host_load(3, 1'b1);
         if (n >= 3) rd_cmp(3);
      end
      // Bad probes leave reads at zero until the host fills the RAM
      for (k = 0; k < 3; k++) begin
         boot(k == 1 ? 8'h00 : 8'h55, k == 0 ? 8'h00 : (k == 1 ? 8'hAA : 8'hAB), 16'h0020);
         chk("host_needed", 10'h001, {9'h000, host_needed});
         chk("ram_valid", 10'h000, {9'h000, ram_valid});
         chk("n_reads", 10'h002, n_reads);
         @(posedge sys_clk) rr_addr <= 8'h07;
         @(posedge sys_clk) #1;
         chk("rr_idle", 10'h000, {2'h0, rr_data});
         chk("iso_idle", 10'h000, {9'h000, iso_bit});
         host_load(20, 1'b0);
         chk("ram_valid", 10'h001, {9'h000, ram_valid});
         chk("host_done", 10'h000, {9'h000, host_needed});
         rd_cmp(20);
         iso_cmp();
      end
      tally_and_finish();
   end
endmodule // rdbl_loader_tb
